// >>> rtl/acs_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"

module acs_top
  import acs_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int RES_W = 10
) (
  input  wire logic             clk_i,        // system clock, 50 MHz
  input  wire logic             rst_i,        // sync reset, high
  input  wire logic             ce_i,         // clock enable, freezes all
  input  wire logic             wb_cyc_i,     // wishbone cycle
  input  wire logic             wb_stb_i,     // wishbone strobe
  input  wire logic             wb_we_i,      // wishbone write
  input  wire logic [ADR_W-1:0] wb_adr_i,     // byte address
  input  wire logic [3:0]       wb_sel_i,     // byte enables
  input  wire logic [31:0]      wb_dat_i,     // write data
  output logic      [31:0]      wb_dat_o,     // read data
  output logic                  wb_ack_o,     // acknowledge
  input  wire logic             rc_tick_i,    // internal rc period pulse
  input  wire logic             sleep_i,      // device asleep
  input  wire logic             comp_i,       // input at or above trial
  output logic                  sample_o,     // hold cap on input pin
  output logic      [RES_W-1:0] trial_o,      // trial code to dac
  output logic      [3:0]       channel_o,    // selected channel
  output logic                  vref_pos_ext_o, // positive ref from pin
  output logic                  vref_neg_ext_o, // negative ref from pin
  output logic      [3:0]       port_cfg_o,   // analog pin layout
  output logic                  converter_on_o, // converter powered
  output logic                  conversion_done_flag_o // done flag
);

  // ---------------- register state
  logic             on_reg;
  logic             go_reg;
  logic [3:0]       ch_reg;
  logic [3:0]       pcfg_reg;
  logic             vpos_reg;
  logic             vneg_reg;
  logic [2:0]       cs_reg;
  logic [2:0]       acq_reg;
  logic             just_reg;
  logic [7:0]       res_hi_reg;
  logic [7:0]       res_lo_reg;
  logic             done_reg;
  logic             ack_reg;
  logic [31:0]      dat_reg;

  // ---------------- sequencer state
  acs_state_type    state_reg;
  acs_state_type    state_next;
  logic [4:0]       cnt_reg;
  logic [4:0]       cnt_next;
  logic [RES_W-1:0] trial_reg;
  logic [RES_W-1:0] mask_reg;
  logic             sample_reg;

  logic             go_next;
  logic             on_next;
  logic             done_next;
  logic             sample_next;
  logic             tad;

  // ---------------- bus decode
  wire              acc      = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master samples ack
  wire              wr_now   = acc & wb_we_i & ack_reg & wb_sel_i[0];
  wire              hit_c1   = (wb_adr_i == ADR_W'(`ACS_CTRL_FIRST_OFS));
  wire              hit_c2   = (wb_adr_i == ADR_W'(`ACS_CTRL_SECOND_OFS));
  wire              hit_c3   = (wb_adr_i == ADR_W'(`ACS_CTRL_THIRD_OFS));
  wire              hit_rh   = (wb_adr_i == ADR_W'(`ACS_RES_HIGH_OFS));
  wire              hit_rl   = (wb_adr_i == ADR_W'(`ACS_RES_LOW_OFS));
  wire              hit_st   = (wb_adr_i == ADR_W'(`ACS_STATUS_OFS));
  wire              wr_c1    = wr_now & hit_c1;
  wire              wr_c2    = wr_now & hit_c2;
  wire              wr_c3    = wr_now & hit_c3;
  wire              wr_rh    = wr_now & hit_rh;
  wire              wr_rl    = wr_now & hit_rl;
  wire              wr_st    = wr_now & hit_st;
  wire [7:0]        wd       = wb_dat_i[7:0];

  wire [7:0]        rd_c1    = {2'b00, ch_reg, go_reg, on_reg};
  wire [7:0]        rd_c2    = {2'b00, vneg_reg, vpos_reg, pcfg_reg};
  wire [7:0]        rd_c3    = {just_reg, 1'b0, acq_reg, cs_reg};
  // status shows only the done flag, nothing about phase
  // no phase status
  wire [7:0]        rd_st    = {7'h00, done_reg};
  wire [7:0]        rd_mux   = hit_c1 ? rd_c1 :
                               hit_c2 ? rd_c2 :
                               hit_c3 ? rd_c3 :
                               hit_rh ? res_hi_reg :
                               hit_rl ? res_lo_reg :
                               hit_st ? rd_st : 8'h00;

  // ---------------- control decode
  wire              use_rc   = (cs_reg[1:0] == `ACS_RC_SEL);
  wire              acq_zero = (acq_reg == 3'b000);
  wire [4:0]        acq_tads = (acq_reg == 3'b111) ? `ACS_ACQ_111 :
                               (acq_reg == 3'b110) ? `ACS_ACQ_110 :
                               (acq_reg == 3'b101) ? `ACS_ACQ_101 :
                               (acq_reg == 3'b100) ? `ACS_ACQ_100 :
                               (acq_reg == 3'b011) ? `ACS_ACQ_011 :
                               (acq_reg == 3'b010) ? `ACS_ACQ_010 :
                               `ACS_ACQ_001;
  wire [4:0]        dly_last = 5'(`ACS_INSTR_CYCLES - 1);

  wire              sw_go_set = wr_c1 & wd[`ACS_GO_BIT] & wd[`ACS_ON_BIT] & on_reg;
  wire              sw_go_clr = wr_c1 & ~wd[`ACS_GO_BIT];
  wire              sw_off    = wr_c1 & ~wd[`ACS_ON_BIT];
  wire              abort     = sw_go_clr | sw_off;

  // ---------------- successive approximation
  wire              in_conv   = (state_reg == acs_st_conv);
  wire              conv_last = in_conv & tad & (cnt_reg == `ACS_CONV_TADS - 5'd1);
  // abort on the last tick still wins: result stays old
  wire              conv_end  = conv_last & ~abort;
  // keep or drop the trial bit
  wire [RES_W-1:0]  trial_dec = comp_i ? trial_reg : (trial_reg & ~mask_reg);
  wire [RES_W-1:0]  trial_nxt = trial_dec | (mask_reg >> 1);
  wire [7:0]        fmt_hi    = just_reg ? {6'h00, trial_dec[9:8]} : trial_dec[9:2];
  wire [7:0]        fmt_lo    = just_reg ? trial_dec[7:0] : {trial_dec[1:0], 6'h00};

  // bit period runs in timed phases
  wire              tad_run   = (state_reg == acs_st_acq) | in_conv | (state_reg == acs_st_gap);

  acs_tad_gen #(
    .CNT_W     (6)
  ) u_tad (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .run_i     (tad_run),
    .sel_i     (cs_reg),
    .rc_tick_i (rc_tick_i),
    .sleep_i   (sleep_i),
    .tad_o     (tad)
  );

  // ---------------- flag next values
  assign on_next = wr_c1 ? wd[`ACS_ON_BIT] : on_reg;

  // software start wins over hardware clear
  assign go_next = sw_go_set ? 1'b1 :
                   (sw_go_clr | sw_off | conv_end) ? 1'b0 : go_reg;

  assign done_next = conv_end | (done_reg & ~(wr_st & wd[`ACS_DONE_BIT]));

  // ---------------- sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      acs_st_idle: begin
        if (on_reg && go_reg && !abort) begin
          // rc source waits an instruction cycle
          if (use_rc) begin
            state_next = acs_st_delay;
          end else if (acq_zero) begin
            state_next = acs_st_conv;
          end else begin
            state_next = acs_st_acq;
          end
        end
      end
      acs_st_delay: begin
        if (abort) begin
          state_next = acs_st_idle;
        end else if (cnt_reg == dly_last) begin
          state_next = acq_zero ? acs_st_conv : acs_st_acq;
        end
      end
      acs_st_acq: begin
        if (abort) begin
          state_next = acs_st_idle;
        end else if (tad && cnt_reg == acq_tads - 5'd1) begin
          state_next = acs_st_conv;
        end
      end
      acs_st_conv: begin
        // software clear aborts to the gap
        if (!on_next) begin
          state_next = acs_st_idle;
        end else if (sw_go_clr || conv_last) begin
          state_next = acs_st_gap;
        end
      end
      acs_st_gap: begin
        // two bit periods before acquiring again
        if (!on_next) begin
          state_next = acs_st_idle;
        end else if (tad && cnt_reg == `ACS_GAP_TADS - 5'd1) begin
          state_next = acs_st_idle;
        end
      end
      default: begin
        state_next = acs_st_idle;
      end
    endcase
  end

  always_comb begin
    if (state_next != state_reg) begin
      cnt_next = 5'd0;
    end else if (state_reg == acs_st_delay || tad) begin
      cnt_next = cnt_reg + 5'd1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  assign sample_next = on_next & ((state_next == acs_st_idle) |
                                  (state_next == acs_st_acq) |
                                  ((state_next == acs_st_delay) & ~acq_zero));

  // ---------------- flops
  // reset clears controls and aborts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= acs_st_idle;
      cnt_reg    <= 5'd0;
      sample_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      sample_reg <= sample_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trial_reg <= '0;
      mask_reg  <= '0;
    end else if (ce_i) begin
      if (state_next == acs_st_conv && !in_conv) begin
        trial_reg <= `ACS_SAR_MSB;
        mask_reg  <= `ACS_SAR_MSB;
      end else if (in_conv && tad && cnt_reg != 5'd0) begin
        trial_reg <= trial_nxt;
        mask_reg  <= mask_reg >> 1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_reg   <= 1'(`ACS_CTRL_FIRST_RST >> `ACS_ON_BIT);
      go_reg   <= 1'b0;
      done_reg <= 1'b0;
      ch_reg   <= 4'h0;
    end else if (ce_i) begin
      on_reg   <= on_next;
      go_reg   <= go_next;
      done_reg <= done_next;
      if (wr_c1) begin
        ch_reg <= wd[`ACS_CH_MSB:`ACS_CH_LSB];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {vneg_reg, vpos_reg, pcfg_reg} <= 6'(`ACS_CTRL_SECOND_RST);
      {just_reg, acq_reg, cs_reg}    <= 7'h00;
    end else if (ce_i) begin
      if (wr_c2) begin
        pcfg_reg <= wd[`ACS_PCFG_MSB:`ACS_PCFG_LSB];
        vpos_reg <= wd[`ACS_VPOS_BIT];
        vneg_reg <= wd[`ACS_VNEG_BIT];
      end
      if (wr_c3) begin
        cs_reg   <= wd[`ACS_CS_MSB:`ACS_CS_LSB];
        acq_reg  <= wd[`ACS_ACQ_MSB:`ACS_ACQ_LSB];
        just_reg <= wd[`ACS_JUST_BIT];
      end
    end
  end

  // result on a finished conversion, otherwise on bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_hi_reg <= `ACS_RES_RST;
      res_lo_reg <= `ACS_RES_RST;
    end else if (ce_i) begin
      if (conv_end) begin
        res_hi_reg <= fmt_hi;
        res_lo_reg <= fmt_lo;
      end else begin
        if (wr_rh) begin
          res_hi_reg <= wd;
        end
        if (wr_rl) begin
          res_lo_reg <= wd;
        end
      end
    end
  end

  // single wait state; bus freezes with ce_i too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= acc & ~ack_reg;
      if (acc && !ack_reg) begin
        dat_reg <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ---------------- outputs
  assign wb_dat_o               = dat_reg;
  assign wb_ack_o               = ack_reg;
  assign sample_o               = sample_reg;
  assign trial_o                = trial_reg;
  assign channel_o              = ch_reg;
  assign vref_pos_ext_o         = vpos_reg;
  assign vref_neg_ext_o         = vneg_reg;
  assign port_cfg_o             = pcfg_reg;
  assign converter_on_o         = on_reg;
  assign conversion_done_flag_o = done_reg;

endmodule
`default_nettype wire

// >>> rtl/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// register byte offsets
`define ACS_CTRL_FIRST_OFS  8'h00
`define ACS_CTRL_SECOND_OFS 8'h04
`define ACS_CTRL_THIRD_OFS  8'h08
`define ACS_RES_HIGH_OFS    8'h0c
`define ACS_RES_LOW_OFS     8'h10
`define ACS_STATUS_OFS      8'h14

// control_first fields
`define ACS_ON_BIT          0
`define ACS_GO_BIT          1
`define ACS_CH_LSB          2
`define ACS_CH_MSB          5
// control_second fields
`define ACS_PCFG_LSB        0
`define ACS_PCFG_MSB        3
`define ACS_VPOS_BIT        4
`define ACS_VNEG_BIT        5
// control_third fields
`define ACS_CS_LSB          0
`define ACS_CS_MSB          2
`define ACS_ACQ_LSB         3
`define ACS_ACQ_MSB         5
`define ACS_JUST_BIT        7
// status fields
`define ACS_DONE_BIT        0

// reset values
`define ACS_CTRL_FIRST_RST  8'h00
`define ACS_CTRL_SECOND_RST 8'h00
`define ACS_CTRL_THIRD_RST  8'h00
`define ACS_RES_RST         8'h00

// timing, in conversion bit periods unless noted
`define ACS_CONV_TADS       5'd11
`define ACS_GAP_TADS        5'd2
`define ACS_ACQ_111         5'd20
`define ACS_ACQ_110         5'd16
`define ACS_ACQ_101         5'd12
`define ACS_ACQ_100         5'd8
`define ACS_ACQ_011         5'd6
`define ACS_ACQ_010         5'd4
`define ACS_ACQ_001         5'd2
`define ACS_CLK_PERIOD_NS   20
`define ACS_INSTR_CYCLE_NS  80
`define ACS_INSTR_CYCLES    ((`ACS_INSTR_CYCLE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_RC_SEL          2'b11
`define ACS_SAR_MSB         10'h200

`endif

// >>> rtl/acs_pkg.sv
package acs_pkg;

  typedef enum logic [2:0] {
    acs_st_idle,
    acs_st_delay,
    acs_st_acq,
    acs_st_conv,
    acs_st_gap
  } acs_state_type;

endpackage

// >>> rtl/acs_tad_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"

module acs_tad_gen #(
  parameter int CNT_W = 6
) (
  input  wire logic       clk_i,     // system clock
  input  wire logic       rst_i,     // sync reset, high
  input  wire logic       ce_i,      // clock enable
  input  wire logic       run_i,     // count while high
  input  wire logic [2:0] sel_i,     // conversion clock select
  input  wire logic       rc_tick_i, // internal rc period pulse
  input  wire logic       sleep_i,   // device asleep
  output logic            tad_o      // one pulse per bit period
);

  logic [CNT_W-1:0] cnt_reg;
  logic             tad_reg;

  // 000:2 100:4 001:8 101:16 010:32 110:64 oscillator periods
  wire              use_rc = (sel_i[1:0] == `ACS_RC_SEL);
  wire [2:0]        expo   = 3'd1 + {2'b00, sel_i[2]} + {sel_i[1:0], 1'b0};
  wire [6:0]        span   = (7'd1 << expo) - 7'd1;
  wire [CNT_W-1:0]  last   = CNT_W'(span);
  // oscillator stops in sleep, only the rc source keeps running
  wire              osc_on = ~sleep_i;
  wire              hit    = use_rc ? rc_tick_i : (osc_on & (cnt_reg == last));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tad_reg <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_reg <= '0;
        tad_reg <= 1'b0;
      end else begin
        tad_reg <= hit;
        if (!use_rc && osc_on) begin
          cnt_reg <= hit ? '0 : cnt_reg + 1'b1;
        end
      end
    end
  end

  assign tad_o = tad_reg;

endmodule
`default_nettype wire

// >>> testbench/acs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"

module acs_monitor #(
  parameter int ADR_W = 8,
  parameter int RES_W = 10
) (
  input wire logic             clk_i,                 // clock
  input wire logic             rst_i,                 // reset
  input wire logic             wb_cyc_i,              // cycle
  input wire logic             wb_stb_i,              // strobe
  input wire logic             wb_we_i,               // write
  input wire logic [ADR_W-1:0] wb_adr_i,              // address
  input wire logic [3:0]       wb_sel_i,              // byte enables
  input wire logic [31:0]      wb_dat_i,              // write data
  input wire logic [31:0]      wb_dat_o,              // read data
  input wire logic             wb_ack_o,              // ack
  input wire logic             sample_o,              // hold cap on pin
  input wire logic             vref_pos_ext_o,        // pos ref
  input wire logic             vref_neg_ext_o,        // neg ref
  input wire logic             converter_on_o,        // on bit
  input wire logic             conversion_done_flag_o // done flag
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_all_off: assert property (disable iff (1'b0) rst_i |=> !converter_on_o && !sample_o && !wb_ack_o
    && !conversion_done_flag_o) else $error("outputs not cleared by reset");
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle after request");
  a_on_bit_write: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `ACS_CTRL_FIRST_OFS
    |=> converter_on_o == $past(wb_dat_i[`ACS_ON_BIT])) else $error("on bit not taken from write");
  a_ref_select: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `ACS_CTRL_SECOND_OFS
    |=> vref_pos_ext_o == $past(wb_dat_i[4]) && vref_neg_ext_o == $past(wb_dat_i[5])) else $error("ref select");
  a_no_progress_bits: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `ACS_STATUS_OFS
    |-> wb_dat_o[31:1] == 31'h0) else $error("status shows extra bits");
  a_done_needs_on: assert property ($rose(conversion_done_flag_o) |-> $past(converter_on_o))
    else $error("done set while converter off");
  a_gap_no_sample: assert property ($rose(conversion_done_flag_o) |-> !sample_o [*3])
    else $error("sampling resumed inside gap");
  a_resume_sample: assert property ($rose(conversion_done_flag_o) |-> ##[1:400] (sample_o || !converter_on_o))
    else $error("sampling not resumed");

  c_done: cover property ($rose(conversion_done_flag_o));
  c_write: cover property (wb_ack_o && wb_we_i);
  c_sample_back: cover property ($rose(sample_o));
endmodule

bind acs_top acs_monitor #(.ADR_W(ADR_W), .RES_W(RES_W)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_o(sample_o), .vref_pos_ext_o(vref_pos_ext_o),
  .vref_neg_ext_o(vref_neg_ext_o), .converter_on_o(converter_on_o), .conversion_done_flag_o(conversion_done_flag_o));
`default_nettype wire

// >>> testbench/acs_analog_model.sv
`timescale 1ns/1ns
`default_nettype none

module acs_analog_model #(
  parameter int RC_PERIOD = 8
) (
  input  wire logic       clk_i,     // clock
  input  wire logic       sample_i,  // hold cap connected
  input  wire logic [9:0] level_i,   // pin level in codes
  input  wire logic [9:0] trial_i,   // trial code
  output logic            comp_o,    // held >= trial
  output logic            rc_tick_o  // rc period pulse
);
  logic [9:0] held = 10'h000;
  int         cnt  = 0;

  // held value only tracks pin while connected
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held <= level_i;
    end
    cnt <= (cnt == RC_PERIOD - 1) ? 0 : cnt + 1;
  end
  assign comp_o = (held >= trial_i);
  // rc source runs free, unrelated to the bus
  assign rc_tick_o = (cnt == 0);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "acs_defines.svh"

module tb_top;
  import acs_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic        sleep = 1'b0;
  logic [9:0]  level = 10'h000;
  wire  [31:0] wb_dat_r;
  wire  [9:0]  trial;
  wire  [3:0]  channel;
  wire  [3:0]  port_cfg;
  wire         wb_ack, rc_tick, comp, sample, vpos, vneg, conv_on, done;
  int          bad_count = 0;
  int          checks = 0;
  logic [2:0]  cs_tab [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int          p_tab [8] = '{2, 4, 8, 16, 32, 64, 8, 8};
  int          t_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  initial forever #10 clk_i = ~clk_i;

  acs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .rc_tick_i(rc_tick), .sleep_i(sleep), .comp_i(comp), .sample_o(sample), .trial_o(trial), .channel_o(channel),
    .vref_pos_ext_o(vpos), .vref_neg_ext_o(vneg), .port_cfg_o(port_cfg), .converter_on_o(conv_on),
    .conversion_done_flag_o(done));
  acs_analog_model #(.RC_PERIOD(8)) u_pins (.clk_i(clk_i), .sample_i(sample), .level_i(level), .trial_i(trial),
    .comp_o(comp), .rc_tick_o(rc_tick));

  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic test_reset_regs;
    logic [31:0] q;
    for (int a = 0; a < 8'h20; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, q);
      check("reset value", 32'h0, q);
    end
    bus(1'b1, 8'h18, 32'hff, q);
    bus(1'b0, 8'h18, 32'h0, q);
    check("unmapped read", 32'h0, q);
    bus(1'b1, `ACS_CTRL_THIRD_OFS, 32'hff, q);
    bus(1'b0, `ACS_CTRL_THIRD_OFS, 32'h0, q);
    check("third reserved bit", 32'hbf, q);
    bus(1'b1, `ACS_CTRL_SECOND_OFS, 32'h3a, q);
    // outputs change on the edge where the write lands; read them one edge later
    wait_cycles(1);
    check("ref and layout", 32'h3a, {26'h0, vneg, vpos, port_cfg});
    bus(1'b1, `ACS_CTRL_FIRST_OFS, 32'h3e, q);
    bus(1'b0, `ACS_CTRL_FIRST_OFS, 32'h0, q);
    check("go while off", 32'h3c, {q[31:1], done});
    check("channel", 32'hf, 32'(channel));
  endtask

  task automatic run_conv(input int i, input int p, input int t, input logic [2:0] cs, input logic [2:0] acq);
    logic [31:0] q;
    logic [9:0]  lvl;
    int          n;
    lvl = 10'h3ff ^ 10'(i * 10'h0cd);
    level <= lvl;
    bus(1'b1, `ACS_CTRL_THIRD_OFS, {24'h0, i[0], 1'b0, acq, cs}, q);
    bus(1'b1, `ACS_CTRL_FIRST_OFS, 32'h1, q);
    // software waits acquisition itself when the field is zero
    wait_cycles(20);
    bus(1'b1, `ACS_CTRL_FIRST_OFS, 32'h3, q);
    wait_cycles(2);
    check("sample during acquisition", 32'(acq != 3'h0), 32'(sample));
    n = 2;
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) begin
      bad_count++;
      stop_test();
    end
    check("cycles in range", 32'h1, 32'(n >= (t + 10) * p + 2 && n <= (t + 12) * p + 6));
    bus(1'b0, `ACS_CTRL_FIRST_OFS, 32'h0, q);
    check("go after done", 32'h1, q);
    bus(1'b0, `ACS_RES_HIGH_OFS, 32'h0, q);
    check("result high", i[0] ? {30'h0, lvl[9:8]} : {24'h0, lvl[9:2]}, q);
    bus(1'b0, `ACS_RES_LOW_OFS, 32'h0, q);
    check("result low", i[0] ? {24'h0, lvl[7:0]} : {24'h0, lvl[1:0], 6'h0}, q);
    bus(1'b1, `ACS_STATUS_OFS, 32'h1, q);
    wait_cycles(1);
    check("done cleared", 32'h0, 32'(done));
    // let the gap end before the next setup touches the clock select
    n = 0;
    while (sample !== 1'b1 && n < 2 * p + 8) begin
      @(posedge clk_i);
      n++;
    end
    check("sample resumed", 32'h1, 32'(sample));
  endtask

  task automatic test_abort_keep;
    logic [31:0] q;
    level <= 10'h0f0;
    bus(1'b1, `ACS_CTRL_THIRD_OFS, 32'h86, q);
    bus(1'b1, `ACS_CTRL_FIRST_OFS, 32'h3, q);
    wait_cycles(300);
    bus(1'b1, `ACS_CTRL_FIRST_OFS, 32'h1, q);
    wait_cycles(900);
    bus(1'b0, `ACS_RES_LOW_OFS, 32'h0, q);
    // last finished result was 3ff, left justified
    check("result kept on abort", 32'hc0, q);
    check("no done on abort", 32'h0, 32'(done));
  endtask

  task automatic test_sleep_reset;
    logic [31:0] q;
    // oscillator periods stop in sleep, so the conversion stalls
    sleep <= 1'b1;
    bus(1'b1, `ACS_CTRL_THIRD_OFS, 32'h80, q);
    bus(1'b1, `ACS_CTRL_FIRST_OFS, 32'h3, q);
    wait_cycles(300);
    check("no done asleep", 32'h1, {31'h0, conv_on & ~done});
    rst_i <= 1'b1;
    wait_cycles(2);
    rst_i <= 1'b0;
    sleep <= 1'b0;
    bus(1'b0, `ACS_CTRL_FIRST_OFS, 32'h0, q);
    check("reset aborts", 32'h0, {q[31:1], conv_on | done | sample});
  endtask

  initial begin
    wait_cycles(6);
    rst_i <= 1'b0;
    test_reset_regs();
    for (int i = 0; i < 8; i++) begin
      // rc entries run asleep for the whole conversion
      sleep <= (i >= 6);
      run_conv(i, p_tab[i], 0, cs_tab[i], 3'h0);
    end
    sleep <= 1'b0;
    for (int a = 1; a < 8; a++) begin
      run_conv(a, 2, t_tab[a], 3'h0, 3'(a));
    end
    run_conv(0, 8, 4, 3'h3, 3'h2);
    test_abort_keep();
    test_sleep_reset();
    stop_test();
  end
endmodule
`default_nettype wire
